// *** rtl/pdt_pkg.sv ***
// Constants and types for the programmable datapath tile
package pdt_pkg;
   // Register indices on the 5-bit address port
   localparam logic [4:0] ADR_ACC0  = 5'h00;
   localparam logic [4:0] ADR_ACC1  = 5'h01;
   localparam logic [4:0] ADR_DAT0  = 5'h02;
   localparam logic [4:0] ADR_DAT1  = 5'h03;
   localparam logic [4:0] ADR_FIFO0 = 5'h04;
   localparam logic [4:0] ADR_FIFO1 = 5'h05;
   localparam logic [4:0] ADR_CTL   = 5'h06;
   localparam logic [4:0] ADR_STS   = 5'h07;
   localparam logic [4:0] ADR_CMSK0 = 5'h08;
   localparam logic [4:0] ADR_CMSK1 = 5'h09;
   localparam logic [4:0] ADR_OMSK  = 5'h0A;
   localparam logic [4:0] ADR_POLY  = 5'h0B;
   localparam logic [4:0] ADR_CFG   = 5'h0C;
   localparam logic [4:0] ADR_OSEL0 = 5'h0D;
   localparam logic [4:0] ADR_OSEL1 = 5'h0E;
   localparam logic [4:0] ADR_OSEL2 = 5'h0F;
   localparam logic [4:0] ADR_FCFG  = 5'h10;
   localparam logic [4:0] ADR_CCFG  = 5'h11;
   localparam logic [4:0] ADR_SMSK  = 5'h12;
   localparam logic [4:0] ADR_FSTAT = 5'h13;
   // Datapath configuration fields
   localparam int CFG_MSB_LSB   = 0;
   localparam int CFG_CMP0_PAIR = 3;
   localparam int CFG_CMP1_LSB  = 4;
   localparam int CFG_TMUX      = 6;
   localparam int CFG_SET       = 7;
   // FIFO and chaining configuration fields
   localparam int FCFG_DIR_LSB  = 0;
   localparam int FCFG_CHAIN    = 2;
   localparam int FCFG_RAND     = 3;
   // Reset values
   localparam logic [7:0] RST_CFG   = 8'h07;
   localparam logic [7:0] RST_MASK  = 8'hFF;
   localparam logic [7:0] RST_CCFG  = 8'h55;
   localparam logic [7:0] RST_OSEL  = 8'hFF;
   // Sub-block enable select codes, two bits each in the clock control reg
   localparam logic [1:0] EN_OFF    = 2'h0;
   localparam logic [1:0] EN_ON     = 2'h1;
   localparam logic [1:0] EN_CTL_LO = 2'h2;
   localparam logic [1:0] EN_CTL_HI = 2'h3;
   localparam int CCFG_LA0 = 0;
   localparam int CCFG_LA1 = 2;
   localparam int CCFG_DP  = 4;
   localparam int CCFG_SC  = 6;
   // Operation code taken from the routing every cycle
   typedef enum logic [2:0] {OP_NOP, OP_ADD, OP_SUB, OP_INC, OP_DEC, OP_SHL, OP_SHR, OP_CRC} pdt_op_e;
endpackage

// *** rtl/pdt_tile.sv ***
// Programmable 8-bit datapath tile with status and control module
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module pdt_tile #(
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire  logic       REF_CLK,
   input  wire  logic       RST,
   // Register port
   input  wire  logic [4:0] ADDR,
   input  wire  logic [7:0] WDATA,
   input  wire  logic       WR,
   input  wire  logic       RD,
   output logic       [7:0] RDATA,
   // Routing matrix
   input  wire  logic [5:0] RT_IN,
   output logic       [5:0] RT_OUT,
   input  wire  logic [7:0] STS_IN,
   output logic       [7:0] CTL_OUT,
   // Logic array block enables
   output logic             LA0_EN,
   output logic             LA1_EN,
   // Neighbour chaining
   input  wire  logic       CHAIN_CI,
   input  wire  logic       CHAIN_SI,
   input  wire  logic       CHAIN_ZI,
   output logic             CHAIN_CO,
   output logic             CHAIN_SO,
   output logic             CHAIN_ZO
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_chk
      $error("DEPTH must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [1:0][7:0]            acc;
      logic [1:0][7:0]            dat;
      logic [7:0]                 ctl;
      logic [1:0][7:0]            cmsk;
      logic [7:0]                 omsk;
      logic [7:0]                 poly;
      logic [7:0]                 cfg;
      logic [2:0][7:0]            osel;
      logic [7:0]                 fcfg;
      logic [7:0]                 ccfg;
      logic [7:0]                 smsk;
      logic [7:0]                 sticky;
      logic [1:0][DEPTH-1:0][7:0] mem;
      logic [1:0][AW:0]           wp;
      logic [1:0][AW:0]           rp;
      logic [3:0]                 cmp;
      logic                       z;
      logic                       ff;
      logic                       ov;
      logic                       co;
      logic                       so;
      logic                       set;
      logic [5:0]                 rt_out;
      logic [1:0]                 la_en;
      logic [7:0]                 rdata;
   } pdt_state_s;

   pdt_state_s st_r;
   pdt_state_s st_nxt;

   // Enable decode, used for all four sub-blocks
   function automatic logic en_sel(input logic [1:0] code, input logic [7:0] ctl, input int k);
      logic r;
      r = 1'b0;
      unique case (code)
         pdt_pkg::EN_OFF:    r = 1'b0;
         pdt_pkg::EN_ON:     r = 1'b1;
         pdt_pkg::EN_CTL_LO: r = ctl[k];
         pdt_pkg::EN_CTL_HI: r = ctl[k + 4];
      endcase
      return r;
   endfunction

   logic [1:0]      fempty;
   logic [1:0]      ffull;
   logic [1:0][7:0] fhead;
   logic            dp_en;
   logic            sc_en;
   logic            s;
   logic            link;
   logic            chain;
   logic [2:0]      msb;
   logic [7:0]      wm;
   logic [7:0]      a;
   logic [7:0]      bp;
   logic            ci;
   logic            si;
   logic [8:0]      sum;
   logic [7:0]      res;
   logic            cout;
   logic            sout;
   logic            ovf;
   logic            alu;

   always_comb
   begin
      st_nxt = st_r;
      for (int i = 0; i < 2; i++)
      begin
         fempty[i] = st_r.wp[i] == st_r.rp[i];
         ffull[i]  = (st_r.wp[i] - st_r.rp[i]) == (AW + 1)'(DEPTH);
         fhead[i]  = st_r.mem[i][st_r.rp[i][AW-1:0]];
      end
      dp_en = en_sel(st_r.ccfg[pdt_pkg::CCFG_DP +: 2], st_r.ctl, 2);
      sc_en = en_sel(st_r.ccfg[pdt_pkg::CCFG_SC +: 2], st_r.ctl, 3);
      st_nxt.la_en[0] = en_sel(st_r.ccfg[pdt_pkg::CCFG_LA0 +: 2], st_r.ctl, 0);
      st_nxt.la_en[1] = en_sel(st_r.ccfg[pdt_pkg::CCFG_LA1 +: 2], st_r.ctl, 1);

      s     = st_r.cfg[pdt_pkg::CFG_TMUX] ? st_r.set : st_r.cfg[pdt_pkg::CFG_SET];
      chain = st_r.fcfg[pdt_pkg::FCFG_CHAIN];
      link  = (st_r.cfg[pdt_pkg::CFG_TMUX] && s) || chain;
      // width mask from the MSB position
      msb = st_r.cfg[pdt_pkg::CFG_MSB_LSB +: 3];
      wm  = 8'((9'h002 << msb) - 9'h001);
      a   = st_r.acc[s] & wm;
      // operation and serial data from the routing
      alu = 1'b1;
      bp  = 8'h00;
      ci  = 1'b0;
      unique case (pdt_pkg::pdt_op_e'(RT_IN[2:0]))
         pdt_pkg::OP_NOP: alu = 1'b0;
         pdt_pkg::OP_ADD: bp = st_r.dat[s];
         pdt_pkg::OP_SUB:
         begin
            bp = ~st_r.dat[s];
            ci = 1'b1;
         end
         pdt_pkg::OP_INC: ci = 1'b1;
         pdt_pkg::OP_DEC: bp = 8'hFF;
         default: bp = 8'h00;
      endcase
      bp = bp & wm;
      // carry and shift data from neighbour or earlier phase
      if (link)
      begin
         ci = chain ? CHAIN_CI : st_r.co;
         si = chain ? CHAIN_SI : st_r.so;
      end
      else
      begin
         si = RT_IN[3];
      end
      sum  = {1'b0, a} + {1'b0, bp} + {8'h00, ci};
      cout = sum[msb + 3'h1 == 3'h0 ? 4'd8 : {1'b0, msb} + 4'd1];
      ovf  = (a[msb] == bp[msb]) && (sum[msb] != a[msb]);
      res  = sum[7:0];
      sout = 1'b0;
      unique case (pdt_pkg::pdt_op_e'(RT_IN[2:0]))
         pdt_pkg::OP_SHL:
         begin
            sout = a[msb];
            res  = 8'(a << 1) | {7'h00, si};
            cout = 1'b0;
            ovf  = 1'b0;
         end
         pdt_pkg::OP_SHR:
         begin
            sout = a[0];
            res  = (a >> 1) | 8'({7'h00, si} << msb);
            cout = 1'b0;
            ovf  = 1'b0;
         end
         pdt_pkg::OP_CRC:
         begin
            // serial input may come from a neighbour
            sout = a[msb] ^ (si & ~st_r.fcfg[pdt_pkg::FCFG_RAND]);
            res  = 8'(a << 1) ^ (sout ? st_r.poly : 8'h00);
            cout = 1'b0;
            ovf  = 1'b0;
         end
         default: sout = 1'b0;
      endcase
      // output mask over the width mask
      res = res & wm & st_r.omsk;

      if (dp_en)
      begin
         st_nxt.set = ~st_r.set;
         if (alu)
         begin
            st_nxt.acc[s] = res;
            st_nxt.z  = res == 8'h00;
            st_nxt.ff = res == (wm & st_r.omsk);
            st_nxt.ov = ovf;
            // carry and shift-out kept for the next cycle
            st_nxt.co = cout;
            st_nxt.so = sout;
         end
         st_nxt.cmp[0] = ((st_r.acc[0] & st_r.cmsk[0]) ==
                          ((st_r.cfg[pdt_pkg::CFG_CMP0_PAIR] ? st_r.acc[1] : st_r.dat[0]) & st_r.cmsk[0]));
         st_nxt.cmp[1] = ((st_r.acc[0] & st_r.cmsk[0]) <
                          ((st_r.cfg[pdt_pkg::CFG_CMP0_PAIR] ? st_r.acc[1] : st_r.dat[0]) & st_r.cmsk[0]));
         unique case (st_r.cfg[pdt_pkg::CFG_CMP1_LSB +: 2])
            2'h0: {a, bp} = {st_r.acc[1], st_r.dat[1]};
            2'h1: {a, bp} = {st_r.acc[0], st_r.acc[1]};
            2'h2: {a, bp} = {st_r.acc[1], st_r.dat[0]};
            2'h3: {a, bp} = {st_r.acc[0], st_r.dat[1]};
         endcase
         st_nxt.cmp[2] = (a & st_r.cmsk[1]) == (bp & st_r.cmsk[1]);
         st_nxt.cmp[3] = (a & st_r.cmsk[1]) < (bp & st_r.cmsk[1]);
      end

      for (int i = 0; i < 2; i++)
      begin
         // direction bit picks the writer and the reader
         if (st_r.fcfg[pdt_pkg::FCFG_DIR_LSB + i])
         begin
            if (dp_en && RT_IN[4 + i] && !ffull[i])
            begin
               st_nxt.mem[i][st_r.wp[i][AW-1:0]] = st_r.acc[i];
               st_nxt.wp[i] = st_r.wp[i] + 1'b1;
            end
            if (RD && ADDR == (i == 0 ? pdt_pkg::ADR_FIFO0 : pdt_pkg::ADR_FIFO1) && !fempty[i])
            begin
               st_nxt.rp[i] = st_r.rp[i] + 1'b1;
            end
         end
         else
         begin
            if (WR && ADDR == (i == 0 ? pdt_pkg::ADR_FIFO0 : pdt_pkg::ADR_FIFO1) && !ffull[i])
            begin
               st_nxt.mem[i][st_r.wp[i][AW-1:0]] = WDATA;
               st_nxt.wp[i] = st_r.wp[i] + 1'b1;
            end
            if (dp_en && RT_IN[4 + i] && !fempty[i])
            begin
               st_nxt.dat[i] = fhead[i];
               st_nxt.rp[i] = st_r.rp[i] + 1'b1;
            end
         end
      end

      for (int k = 0; k < 6; k++)
      begin
         st_nxt.rt_out[k] = 1'b0;
         unique case (st_r.osel[k / 2][4 * (k % 2) +: 4])
            4'h0: st_nxt.rt_out[k] = st_r.cmp[0];
            4'h1: st_nxt.rt_out[k] = st_r.cmp[1];
            4'h2: st_nxt.rt_out[k] = st_r.cmp[2];
            4'h3: st_nxt.rt_out[k] = st_r.cmp[3];
            4'h4: st_nxt.rt_out[k] = st_r.z & (~chain | CHAIN_ZI);
            4'h5: st_nxt.rt_out[k] = st_r.ff;
            4'h6: st_nxt.rt_out[k] = st_r.ov;
            4'h7: st_nxt.rt_out[k] = st_r.co;
            4'h8: st_nxt.rt_out[k] = st_r.so;
            4'h9: st_nxt.rt_out[k] = fempty[0];
            4'hA: st_nxt.rt_out[k] = ffull[0];
            4'hB: st_nxt.rt_out[k] = fempty[1];
            4'hC: st_nxt.rt_out[k] = ffull[1];
            4'hD: st_nxt.rt_out[k] = !fempty[0];
            4'hE: st_nxt.rt_out[k] = !fempty[1];
            4'hF: st_nxt.rt_out[k] = 1'b0;
         endcase
      end

      // sticky capture, read clears, set wins
      if (RD && ADDR == pdt_pkg::ADR_STS)
      begin
         st_nxt.sticky = 8'h00;
      end
      if (sc_en)
      begin
         st_nxt.sticky = st_nxt.sticky | (STS_IN & st_r.smsk);
      end

      // Register writes; bus beats datapath on a shared register
      if (WR)
      begin
         unique case (ADDR)
            pdt_pkg::ADR_ACC0:  st_nxt.acc[0] = WDATA;
            pdt_pkg::ADR_ACC1:  st_nxt.acc[1] = WDATA;
            pdt_pkg::ADR_DAT0:  st_nxt.dat[0] = WDATA;
            pdt_pkg::ADR_DAT1:  st_nxt.dat[1] = WDATA;
            pdt_pkg::ADR_CTL:   st_nxt.ctl = WDATA;
            pdt_pkg::ADR_CMSK0: st_nxt.cmsk[0] = WDATA;
            pdt_pkg::ADR_CMSK1: st_nxt.cmsk[1] = WDATA;
            pdt_pkg::ADR_OMSK:  st_nxt.omsk = WDATA;
            pdt_pkg::ADR_POLY:  st_nxt.poly = WDATA;
            pdt_pkg::ADR_CFG:   st_nxt.cfg = WDATA;
            pdt_pkg::ADR_OSEL0: st_nxt.osel[0] = WDATA;
            pdt_pkg::ADR_OSEL1: st_nxt.osel[1] = WDATA;
            pdt_pkg::ADR_OSEL2: st_nxt.osel[2] = WDATA;
            pdt_pkg::ADR_FCFG:  st_nxt.fcfg = {4'h0, WDATA[3:0]};
            pdt_pkg::ADR_CCFG:  st_nxt.ccfg = WDATA;
            pdt_pkg::ADR_SMSK:  st_nxt.smsk = WDATA;
            default:            st_nxt.ctl = st_nxt.ctl;
         endcase
      end

      // Read data stands for one cycle only
      st_nxt.rdata = 8'h00;
      if (RD)
      begin
         unique case (ADDR)
            pdt_pkg::ADR_ACC0:  st_nxt.rdata = st_r.acc[0];
            pdt_pkg::ADR_ACC1:  st_nxt.rdata = st_r.acc[1];
            pdt_pkg::ADR_DAT0:  st_nxt.rdata = st_r.dat[0];
            pdt_pkg::ADR_DAT1:  st_nxt.rdata = st_r.dat[1];
            // Empty or input-direction FIFO reads as zero
            pdt_pkg::ADR_FIFO0:
               st_nxt.rdata = (fempty[0] || !st_r.fcfg[0]) ? 8'h00 : fhead[0];
            pdt_pkg::ADR_FIFO1:
               st_nxt.rdata = (fempty[1] || !st_r.fcfg[1]) ? 8'h00 : fhead[1];
            pdt_pkg::ADR_CTL:   st_nxt.rdata = st_r.ctl;
            // live routing bits, sticky where masked
            // each bit has its own routing line
            pdt_pkg::ADR_STS:   st_nxt.rdata = st_r.sticky | (STS_IN & ~st_r.smsk);
            pdt_pkg::ADR_CMSK0: st_nxt.rdata = st_r.cmsk[0];
            pdt_pkg::ADR_CMSK1: st_nxt.rdata = st_r.cmsk[1];
            pdt_pkg::ADR_OMSK:  st_nxt.rdata = st_r.omsk;
            pdt_pkg::ADR_POLY:  st_nxt.rdata = st_r.poly;
            pdt_pkg::ADR_CFG:   st_nxt.rdata = st_r.cfg;
            pdt_pkg::ADR_OSEL0: st_nxt.rdata = st_r.osel[0];
            pdt_pkg::ADR_OSEL1: st_nxt.rdata = st_r.osel[1];
            pdt_pkg::ADR_OSEL2: st_nxt.rdata = st_r.osel[2];
            pdt_pkg::ADR_FCFG:  st_nxt.rdata = st_r.fcfg;
            pdt_pkg::ADR_CCFG:  st_nxt.rdata = st_r.ccfg;
            pdt_pkg::ADR_SMSK:  st_nxt.rdata = st_r.smsk;
            pdt_pkg::ADR_FSTAT:
               st_nxt.rdata = {st_r.z, st_r.ff, st_r.ov, st_r.co, ffull[1], fempty[1], ffull[0], fempty[0]};
            default:            st_nxt.rdata = 8'h00;
         endcase
      end
   end

   // reset clears data, empties FIFOs, drops control
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         st_r         <= '0;
         st_r.cfg     <= pdt_pkg::RST_CFG;
         st_r.cmsk    <= {pdt_pkg::RST_MASK, pdt_pkg::RST_MASK};
         st_r.omsk    <= pdt_pkg::RST_MASK;
         st_r.ccfg    <= pdt_pkg::RST_CCFG;
         st_r.osel    <= {3{pdt_pkg::RST_OSEL}};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign RT_OUT   = st_r.rt_out;
   assign CTL_OUT  = st_r.ctl;
   assign RDATA    = st_r.rdata;
   assign LA0_EN   = st_r.la_en[0];
   assign LA1_EN   = st_r.la_en[1];
   assign CHAIN_CO = st_r.co;
   assign CHAIN_SO = st_r.so;
   assign CHAIN_ZO = st_r.z;
endmodule

`default_nettype wire

// *** test/pdt_tile_properties.sv ***
// Port assertions for the datapath tile, bound into its top module
`timescale 1ns/1ps
`default_nettype none
module pdt_tile_props (
   // Clock and reset
   input wire logic       REF_CLK,
   input wire logic       RST,
   // Register port
   input wire logic [4:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   // Routing side
   input wire logic [5:0] RT_OUT,
   input wire logic [7:0] STS_IN,
   input wire logic [7:0] CTL_OUT,
   input wire logic       LA0_EN,
   input wire logic       CHAIN_CO
);
   default clocking @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   // Set once any output select is written
   logic sel_wr_r;
   always_ff @(posedge REF_CLK)
      if (RST)
         sel_wr_r <= 1'b0;
      else if (WR && ADDR >= pdt_pkg::ADR_OSEL0 && ADDR <= pdt_pkg::ADR_OSEL2)
         sel_wr_r <= 1'b1;

   AST_RDATA_IDLE:
   assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("read data seen without a read");
   AST_UNMAPPED:
   assert property (RD && ADDR > pdt_pkg::ADR_FSTAT |=> RDATA == 8'h00)
      else $error("unmapped read not zero");
   AST_CTL_WRITE:
   assert property (WR && ADDR == pdt_pkg::ADR_CTL |=> CTL_OUT == $past(WDATA))
      else $error("control write not on outputs");
   AST_CTL_HOLD:
   assert property (!(WR && ADDR == pdt_pkg::ADR_CTL) |=> $stable(CTL_OUT))
      else $error("control outputs moved without a write");
   AST_STS_LIVE:
   assert property (RD && ADDR == pdt_pkg::ADR_STS && $stable(STS_IN) |=> ($past(STS_IN) & ~RDATA) == 8'h00)
      else $error("status read lost a live line");
   AST_STICKY_CLR:
   assert property ((STS_IN == 8'h00)[*3] ##0 (RD && ADDR == pdt_pkg::ADR_STS)
                    ##1 (RD && ADDR == pdt_pkg::ADR_STS && STS_IN == 8'h00) |=> RDATA == 8'h00)
      else $error("held event not cleared by read");
   AST_LA0_OFF:
   assert property (WR && ADDR == pdt_pkg::ADR_CCFG && WDATA[1:0] == pdt_pkg::EN_OFF |-> ##[1:2] !LA0_EN)
      else $error("array enable stayed on");
   AST_RST_STATE:
   assert property ($fell(RST) |-> CTL_OUT == 8'h00 && RT_OUT == 6'h00 && RDATA == 8'h00 && !CHAIN_CO)
      else $error("outputs not cleared by reset");
   AST_SEL_ZERO:
   assert property (!sel_wr_r |-> RT_OUT == 6'h00)
      else $error("routing output set with constant select");
endmodule

bind pdt_tile pdt_tile_props u_props (
   .REF_CLK  (REF_CLK),
   .RST      (RST),
   .ADDR     (ADDR),
   .WDATA    (WDATA),
   .WR       (WR),
   .RD       (RD),
   .RDATA    (RDATA),
   .RT_OUT   (RT_OUT),
   .STS_IN   (STS_IN),
   .CTL_OUT  (CTL_OUT),
   .LA0_EN   (LA0_EN),
   .CHAIN_CO (CHAIN_CO)
);
`default_nettype wire

// *** test/pdt_route_model.sv ***
// Routing-side model: operation, strobes and status lines for the tile
`timescale 1ns/1ps
`default_nettype none
module pdt_route_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Requests from the bench
   input  wire logic [2:0] op,
   input  wire logic       ser,
   input  wire logic       str0,
   input  wire logic       str1,
   input  wire logic [7:0] sts,
   // Tile side
   input  wire logic [7:0] ctl,
   output logic      [5:0] rt_in,
   output logic      [7:0] sts_in
);
   // Registered like real routing, so one cycle of lag
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rt_in  <= 6'h00;
         sts_in <= 8'h00;
      end
      else
      begin
         rt_in  <= {str1, str0, ser, op};
         sts_in <= sts ^ ctl;
      end
   end
endmodule
`default_nettype wire

// *** test/pdt_tile_test.sv ***
// Self-checking bench for the datapath tile
`timescale 1ns/1ps
`default_nettype none
module pdt_tile_test;
   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] msk;
      logic [7:0] acc;
      logic [7:0] dat;
      logic [2:0] op;
      logic [7:0] res;
      logic [5:0] rt;
   } pdt_alu_s;
   logic        clk;
   logic        rst  = 1'b1;
   logic        wr   = 1'b0;
   logic        rd   = 1'b0;
   logic        rd_q = 1'b0;
   logic        str0 = 1'b0;
   logic        str1 = 1'b0;
   logic [2:0]  op   = pdt_pkg::OP_NOP;
   logic [4:0]  adr  = 5'h00;
   logic [7:0]  wd   = 8'h00;
   logic [7:0]  sts  = 8'h00;
   logic [7:0]  rnd  = 8'h45;
   logic [7:0]  rdata, ctl_out, sts_in;
   logic [5:0]  rt_out, rt_in;
   logic        la0, la1;
   logic        co, so, zo;
   logic [7:0]  exp_q[$];
   logic [7:0]  fq[$];
   int          bad_count = 0;
   int          n_checks  = 0;
   logic [12:0] rst_tab[10] = '{{pdt_pkg::ADR_CFG, pdt_pkg::RST_CFG}, {pdt_pkg::ADR_CMSK0, pdt_pkg::RST_MASK},
      {pdt_pkg::ADR_CMSK1, pdt_pkg::RST_MASK}, {pdt_pkg::ADR_OMSK, pdt_pkg::RST_MASK},
      {pdt_pkg::ADR_CCFG, pdt_pkg::RST_CCFG}, {pdt_pkg::ADR_OSEL0, pdt_pkg::RST_OSEL},
      {pdt_pkg::ADR_OSEL2, pdt_pkg::RST_OSEL}, {pdt_pkg::ADR_ACC0, 8'h00}, {pdt_pkg::ADR_DAT1, 8'h00}, {5'h1F, 8'h00}};
   logic [18:0] cmp_tab[7] = '{{pdt_pkg::ADR_OSEL0, 8'h20, 6'h03}, {pdt_pkg::ADR_ACC0, 8'h5A, 6'h02},
      {pdt_pkg::ADR_DAT0, 8'h5B, 6'h02}, {pdt_pkg::ADR_CMSK0, 8'hFE, 6'h03}, {pdt_pkg::ADR_CMSK0, 8'hFF, 6'h02},
      {pdt_pkg::ADR_CFG, 8'h17, 6'h00}, {pdt_pkg::ADR_ACC1, 8'h5A, 6'h02}};
   pdt_alu_s    alu_tab[5] = '{'{8'h07, 8'hFF, 8'hF0, 8'h10, pdt_pkg::OP_ADD, 8'h00, 6'h03},
      '{8'h07, 8'hFF, 8'h7F, 8'h01, pdt_pkg::OP_ADD, 8'h80, 6'h00},
      '{8'h03, 8'h0F, 8'h0F, 8'h01, pdt_pkg::OP_ADD, 8'h00, 6'h03},
      '{8'h03, 8'h0F, 8'h0E, 8'h01, pdt_pkg::OP_INC, 8'h0F, 6'h00},
      '{8'h07, 8'hFF, 8'h80, 8'h00, pdt_pkg::OP_CRC, 8'h00, 6'h01}};

   pdt_tile DUT (
      .REF_CLK (clk), .RST (rst), .ADDR (adr), .WDATA (wd), .WR (wr), .RD (rd), .RDATA (rdata),
      .RT_IN (rt_in), .RT_OUT (rt_out), .STS_IN (sts_in), .CTL_OUT (ctl_out), .LA0_EN (la0), .LA1_EN (la1),
      .CHAIN_CI (1'b0), .CHAIN_SI (1'b0), .CHAIN_ZI (1'b0), .CHAIN_CO (co), .CHAIN_SO (so), .CHAIN_ZO (zo)
   );
   pdt_route_model u_route (
      .clk (clk), .rst (rst), .op (op), .ser (1'b0), .str0 (str0), .str1 (str1),
      .sts (sts), .ctl (ctl_out), .rt_in (rt_in), .sts_in (sts_in)
   );

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   function automatic logic [7:0] nxt_rnd(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Strobes go low here, in act, and in wreg or rreg for the strobe that task does not use
   task automatic step(input int n);
      wr   <= 1'b0;
      rd   <= 1'b0;
      op   <= pdt_pkg::OP_NOP;
      str0 <= 1'b0;
      str1 <= 1'b0;
      repeat (n) @(posedge clk);
   endtask

   task automatic wreg(input logic [4:0] a, input logic [7:0] d);
      wr  <= 1'b1;
      rd  <= 1'b0;
      adr <= a;
      wd  <= d;
      @(posedge clk);
   endtask

   task automatic rreg(input logic [4:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      rd  <= 1'b1;
      wr  <= 1'b0;
      adr <= a;
      @(posedge clk);
   endtask

   task automatic act(input logic [2:0] o, input logic a, input logic b);
      op   <= o;
      str0 <= a;
      str1 <= b;
      wr   <= 1'b0;
      rd   <= 1'b0;
      @(posedge clk);
   endtask

   task automatic end_of_test();
      if (bad_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Read data stands only in the cycle after the strobe
   always @(posedge clk)
   begin
      if (rd_q)
         chk(rdata, exp_q.pop_front());
      rd_q <= rd;
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      bad_count++;
      end_of_test();
   end

   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      step(2);
      chk(ctl_out, 8'h00);
      chk({2'h0, rt_out}, 8'h00);
      foreach (rst_tab[i])
         rreg(rst_tab[i][12:8], rst_tab[i][7:0]);
      rnd = nxt_rnd(rnd);
      wreg(pdt_pkg::ADR_CTL, rnd);
      step(4);
      chk(ctl_out, rnd);
      rreg(pdt_pkg::ADR_STS, rnd);
      wreg(pdt_pkg::ADR_CTL, 8'h00);
      repeat (4)
      begin
         rnd = nxt_rnd(rnd);
         sts <= rnd;
         step(4);
         rreg(pdt_pkg::ADR_STS, rnd);
      end
      sts <= 8'h00;
      step(4);
      wreg(pdt_pkg::ADR_SMSK, 8'hFF);
      sts <= 8'h81;
      step(1);
      sts <= 8'h00;
      step(5);
      rreg(pdt_pkg::ADR_STS, 8'h81);
      rreg(pdt_pkg::ADR_STS, 8'h00);
      wreg(pdt_pkg::ADR_SMSK, 8'h00);
      // Enable codes: off, then control bits 4 and 1
      wreg(pdt_pkg::ADR_CCFG, 8'h54);
      step(3);
      chk({6'h00, la1, la0}, 8'h02);
      wreg(pdt_pkg::ADR_CCFG, 8'h5B);
      wreg(pdt_pkg::ADR_CTL, 8'h10);
      step(3);
      chk({6'h00, la1, la0}, 8'h01);
      wreg(pdt_pkg::ADR_CTL, 8'h02);
      step(3);
      chk({6'h00, la1, la0}, 8'h02);
      wreg(pdt_pkg::ADR_CCFG, pdt_pkg::RST_CCFG);
      wreg(pdt_pkg::ADR_CTL, 8'h00);
      foreach (cmp_tab[i])
      begin
         wreg(cmp_tab[i][18:14], cmp_tab[i][13:6]);
         step(4);
         chk({2'h0, rt_out}, {2'h0, cmp_tab[i][5:0]});
      end
      // Zero on out0, carry on out1
      wreg(pdt_pkg::ADR_OSEL0, 8'h74);
      foreach (alu_tab[i])
      begin
         wreg(pdt_pkg::ADR_CFG, alu_tab[i].cfg);
         wreg(pdt_pkg::ADR_OMSK, alu_tab[i].msk);
         wreg(pdt_pkg::ADR_ACC0, alu_tab[i].acc);
         wreg(pdt_pkg::ADR_DAT0, alu_tab[i].dat);
         act(alu_tab[i].op, 1'b0, 1'b0);
         step(4);
         chk({2'h0, rt_out}, {2'h0, alu_tab[i].rt});
         chk({6'h00, co, zo}, {2'h0, alu_tab[i].rt});
         rreg(pdt_pkg::ADR_ACC0, alu_tab[i].res);
      end
      wreg(pdt_pkg::ADR_CFG, pdt_pkg::RST_CFG);
      wreg(pdt_pkg::ADR_OMSK, pdt_pkg::RST_MASK);
      wreg(pdt_pkg::ADR_FCFG, 8'h01);
      wreg(pdt_pkg::ADR_OSEL0, 8'hA9);
      step(4);
      chk({2'h0, rt_out}, 8'h01);
      // Fifth push must be refused
      for (int i = 0; i < 5; i++)
      begin
         rnd = nxt_rnd(rnd);
         wreg(pdt_pkg::ADR_ACC0, rnd);
         if (i < 4)
            fq.push_back(rnd);
         act(pdt_pkg::OP_NOP, 1'b1, 1'b0);
         step(1);
      end
      step(3);
      chk({2'h0, rt_out}, 8'h02);
      while (fq.size() > 0)
         rreg(pdt_pkg::ADR_FIFO0, fq.pop_front());
      step(4);
      chk({2'h0, rt_out}, 8'h01);
      wreg(pdt_pkg::ADR_FCFG, 8'h00);
      wreg(pdt_pkg::ADR_OSEL0, 8'hCB);
      repeat (5)
      begin
         rnd = nxt_rnd(rnd);
         wreg(pdt_pkg::ADR_FIFO1, rnd);
         fq.push_back(rnd);
      end
      // Fifth write is refused, so its note goes
      fq.delete(fq.size() - 1);
      step(4);
      chk({2'h0, rt_out}, 8'h02);
      for (int i = 0; i < 5; i++)
      begin
         act(pdt_pkg::OP_NOP, 1'b0, 1'b1);
         step(4);
         chk({2'h0, rt_out}, (i < 3) ? 8'h00 : 8'h01);
         if (i < 4)
            rreg(pdt_pkg::ADR_DAT1, fq.pop_front());
      end
      step(2);
      end_of_test();
   end
endmodule
`default_nettype wire
